// >>> fsw_top.sv
// fault supervisor: halt input, watchdog, overheat, gp i/o, safe outputs
//
// Operation
// - three fault sources: external halt, watchdog expiry, overheat
// - halt mode on and halt input off records external halt fault
// - external halt stops processing, shows red, stays until reset
// - fault with halt mode drives logic and isolated outputs to safe states
// - protected-boot switch on makes halt mode ignored while the switch stays on
// - fault state and held outputs persist until a reset
// - front-panel reset accepted only after two-second continuous press
// - halt mode stays in force until reset once enabled
// - watchdog timeout in 1 ms steps up to 65534 ms
// - watchdog action: notify only, drive first logic output, or halt
// - notify mode expired flag true after expiry until disarm
// - drive mode: first logic output high on expiry until disarm
// - halt mode: expiry halts, red indicator, safe outputs if halt mode
// - overheat halts, red indicator, safe outputs if halt mode
// - software samples gp inputs any time and sets gp outputs only while not halted
// - gp inputs never start a timed pulse generator
// - gp outputs change on software writes, watchdog drive action and safe states
`timescale 1ns/1ns
`include "fsw_defines.svh"
module fsw_top
    import fsw_pkg::*;
#(
    parameter int MS_CYCLES = `FSW_MS_CYCLES,
    parameter int PRESS_CYCLES = `FSW_PRESS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // field pins, asynchronous to clk
    input wire logic halt_req_pin,
    input wire logic overheat_pin,
    input wire logic reset_btn_pin,
    input wire logic protect_boot_pin,
    input wire logic [`FSW_GPI_N-1:0] gp_in_pin,
    // software configuration and control
    input wire logic halt_mode_en,
    input wire fsw_wd_cfg_t wd_cfg,
    input wire logic wd_service,
    input wire fsw_safe_cfg_t safe_cfg,
    input wire logic ttl_wr,
    input wire logic [`FSW_TTL_N-1:0] ttl_wr_data,
    input wire logic iso_wr,
    input wire logic [`FSW_ISO_N-1:0] iso_wr_data,
    // logic-level outputs with enables, isolated outputs
    output logic [`FSW_TTL_N-1:0] ttl_out,
    output logic [`FSW_TTL_N-1:0] ttl_oe,
    output logic [`FSW_ISO_N-1:0] iso_out,
    // status toward software and the front panel
    output logic [`FSW_GPI_N-1:0] gp_in_val,
    output fsw_fault_t fault,
    output logic halted,
    output logic health_red,
    output logic halt_mode_active,
    output logic wd_expired,
    output logic panel_reset
);

    logic [`FSW_SY_W-1:0] pin_sync;
    logic halt_req_s;
    logic heat_s;
    logic btn_s;
    logic boot_s;
    logic panel_ok;
    logic clr;
    logic [1:0] settle_ff;
    logic ready;
    logic halt_latch_ff;
    logic halt_eff;
    logic [`FSW_TICK_W-1:0] tick_cnt_ff;
    logic tick;
    logic [15:0] ms_cnt_ff;
    logic [15:0] wd_limit;
    logic wd_exp_ff;
    logic wd_hit;
    fsw_fault_t fault_ff;
    fsw_fault_t nxt_fault;
    fsw_state_t state_ff;
    fsw_state_t nxt_state;
    logic safe_ff;
    logic nxt_safe;
    logic [`FSW_TTL_N-1:0] ttl_lvl_ff;
    logic [`FSW_ISO_N-1:0] iso_lvl_ff;
    logic [`FSW_TTL_N-1:0] nxt_ttl_out;
    logic [`FSW_TTL_N-1:0] nxt_ttl_oe;
    logic [`FSW_ISO_N-1:0] nxt_iso_out;
    logic [`FSW_TTL_N-1:0] ttl_out_ff;
    logic [`FSW_TTL_N-1:0] ttl_oe_ff;
    logic [`FSW_ISO_N-1:0] iso_out_ff;
    logic [`FSW_GPI_N-1:0] gp_in_ff;
    logic halted_ff;
    logic red_ff;
    logic halt_act_ff;
    logic wd_flag_ff;
    logic panel_ff;

    // every pin passes two flops before any logic looks at it
    fsw_sync #(
        .W(`FSW_SY_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({protect_boot_pin, reset_btn_pin, overheat_pin, halt_req_pin,
            gp_in_pin}),
        .q(pin_sync)
    );

    assign halt_req_s = pin_sync[`FSW_SY_HALT];
    assign heat_s = pin_sync[`FSW_SY_HEAT];
    assign btn_s = pin_sync[`FSW_SY_BTN];
    assign boot_s = pin_sync[`FSW_SY_BOOT];

    // long press on the front button acts as a device reset
    fsw_press #(
        .HOLD(PRESS_CYCLES)
    ) u_press (
        .clk(clk),
        .rst_n(rst_n),
        .pressed(btn_s),
        .accept(panel_ok)
    );

    // panel reset clears all state that uses clr; the synchroniser, press detector, gp sample and echo see only rst_n
    assign clr = !rst_n || panel_ok;

    // hold off pin faults until the synchroniser holds real samples,
    // otherwise its reset zeros would look like a dropped halt input
    always_ff @(posedge clk)
    begin
        if (clr)
            settle_ff <= 2'h0;
        else if (settle_ff != `FSW_SETTLE_DONE)
            settle_ff <= settle_ff + 2'h1;
    end

    assign ready = (settle_ff == `FSW_SETTLE_DONE);

    // halt mode latches on; dropping the enable only counts after reset
    always_ff @(posedge clk)
    begin
        if (clr)
            halt_latch_ff <= 1'b0;
        else if (halt_mode_en)
            halt_latch_ff <= 1'b1;
    end

    // protected boot overrides the latched halt mode
    assign halt_eff = halt_latch_ff & ~boot_s;

    // millisecond prescaler; service restarts the partial millisecond too
    always_ff @(posedge clk)
    begin
        if (clr || !wd_cfg.arm || wd_service || wd_exp_ff)
            tick_cnt_ff <= '0;
        else if (tick)
            tick_cnt_ff <= '0;
        else
            tick_cnt_ff <= tick_cnt_ff + `FSW_TICK_W'(1);
    end

    assign tick = (tick_cnt_ff == `FSW_TICK_W'(MS_CYCLES - 1));

    // elapsed milliseconds since arm or last service
    always_ff @(posedge clk)
    begin
        if (clr || !wd_cfg.arm || wd_service)
            ms_cnt_ff <= 16'h0000;
        else if (tick)
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
    end

    // zero would expire at once and above the top is out of range
    always_comb
    begin
        if (wd_cfg.timeout_ms < `FSW_WD_MIN_MS)
            wd_limit = `FSW_WD_MIN_MS;
        else if (wd_cfg.timeout_ms > `FSW_WD_MAX_MS)
            wd_limit = `FSW_WD_MAX_MS;
        else
            wd_limit = wd_cfg.timeout_ms;
    end

    // expiry is sticky until disarm; a service in the expiry cycle loses
    always_ff @(posedge clk)
    begin
        if (clr || !wd_cfg.arm)
            wd_exp_ff <= 1'b0;
        else if (ms_cnt_ff >= wd_limit)
            wd_exp_ff <= 1'b1;
    end

    // only the halt action turns an expiry into a fault
    assign wd_hit = wd_exp_ff && (wd_cfg.action == FSW_WD_HALT);

    // fault causes gather and stick; nothing but reset clears them
    always_comb
    begin
        nxt_fault = fault_ff;
        if (ready && halt_eff && !halt_req_s)
            nxt_fault.ext = 1'b1;
        if (wd_hit)
            nxt_fault.wd = 1'b1;
        if (ready && heat_s)
            nxt_fault.heat = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (clr)
            fault_ff <= '0;
        else
            fault_ff <= nxt_fault;
    end

    // supervisor: run until any cause appears, then stay halted
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            FSW_RUN:
            begin
                if (nxt_fault != '0)
                    nxt_state = FSW_FAULT;
            end
            FSW_FAULT:
                nxt_state = FSW_FAULT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (clr)
            state_ff <= FSW_RUN;
        else
            state_ff <= nxt_state;
    end

    // safe states are chosen at the fault and kept, so a later move of
    // the boot switch cannot release outputs before a reset
    assign nxt_safe = safe_ff || (nxt_state == FSW_FAULT && halt_eff);

    always_ff @(posedge clk)
    begin
        if (clr)
            safe_ff <= 1'b0;
        else
            safe_ff <= nxt_safe;
    end

    // software levels; frozen once halted so outputs stay where they were
    always_ff @(posedge clk)
    begin
        if (clr)
            ttl_lvl_ff <= `FSW_TTL_RST;
        else if (ttl_wr && state_ff == FSW_RUN)
            ttl_lvl_ff <= ttl_wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (clr)
            iso_lvl_ff <= `FSW_ISO_RST;
        else if (iso_wr && state_ff == FSW_RUN)
            iso_lvl_ff <= iso_wr_data;
    end

    // output selection: safe states win over software and watchdog
    always_comb
    begin
        nxt_ttl_out = ttl_lvl_ff;
        nxt_ttl_oe = '1;
        nxt_iso_out = iso_lvl_ff;
        if (wd_cfg.action == FSW_WD_DRIVE)
            nxt_ttl_out[0] = wd_exp_ff;
        if (nxt_safe)
        begin
            nxt_iso_out = safe_cfg.iso;
            nxt_ttl_out[0] = (safe_cfg.ttl0 == FSW_SAFE_HIGH);
            nxt_ttl_oe[0] = (safe_cfg.ttl0 != FSW_SAFE_HIZ);
            nxt_ttl_out[1] = (safe_cfg.ttl1 == FSW_SAFE_HIGH);
            nxt_ttl_oe[1] = (safe_cfg.ttl1 != FSW_SAFE_HIZ);
        end
    end

    // pin drivers; enables low in reset; frozen in the fault state so a
    // late expiry, disarm or safe-state edit cannot move a held output
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            ttl_out_ff <= `FSW_TTL_RST;
            ttl_oe_ff <= '0;
            iso_out_ff <= `FSW_ISO_RST;
        end
        else if (state_ff == FSW_RUN)
        begin
            ttl_out_ff <= nxt_ttl_out;
            ttl_oe_ff <= nxt_ttl_oe;
            iso_out_ff <= nxt_iso_out;
        end
    end

    // gp inputs only reach this sample register, never a pulse start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            gp_in_ff <= '0;
        else
            gp_in_ff <= pin_sync[`FSW_SY_GPI +: `FSW_GPI_N];
    end

    // status flags toward software and the health indicator
    always_ff @(posedge clk)
    begin
        if (clr)
        begin
            halted_ff <= 1'b0;
            red_ff <= 1'b0;
            halt_act_ff <= 1'b0;
            wd_flag_ff <= 1'b0;
        end
        else
        begin
            halted_ff <= (nxt_state == FSW_FAULT);
            red_ff <= (nxt_state == FSW_FAULT);
            halt_act_ff <= halt_eff;
            wd_flag_ff <= wd_exp_ff && wd_cfg.arm;
        end
    end

    // panel reset pulse is echoed so the rest of the system can follow
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            panel_ff <= 1'b0;
        else
            panel_ff <= panel_ok;
    end

    assign ttl_out = ttl_out_ff;
    assign ttl_oe = ttl_oe_ff;
    assign iso_out = iso_out_ff;
    assign gp_in_val = gp_in_ff;
    assign fault = fault_ff;
    assign halted = halted_ff;
    assign health_red = red_ff;
    assign halt_mode_active = halt_act_ff;
    assign wd_expired = wd_flag_ff;
    assign panel_reset = panel_ff;

endmodule

// >>> fsw_defines.svh
// timing counts, field positions and reset values for the fault watchdog
`ifndef FSW_DEFINES_SVH
`define FSW_DEFINES_SVH

// clock period and time units, figures in their own unit
`define FSW_CLK_NS 50
`define FSW_MS_NS 1000000
`define FSW_PRESS_MS 2000

// derived cycle counts (both above 4096, so top-level parameters)
`define FSW_MS_CYCLES (`FSW_MS_NS / `FSW_CLK_NS)
`define FSW_PRESS_CYCLES (`FSW_PRESS_MS * (`FSW_MS_NS / `FSW_CLK_NS))

// counter widths sized for the counts above
`define FSW_TICK_W 15
`define FSW_PRESS_W 26

// watchdog limits in milliseconds
`define FSW_WD_MAX_MS 16'hFFFE
`define FSW_WD_MIN_MS 16'h0001

// output and gp input lane counts
`define FSW_TTL_N 2
`define FSW_ISO_N 4
`define FSW_GPI_N 2

// positions inside the synchroniser bundle
`define FSW_SY_GPI 0
`define FSW_SY_HALT 2
`define FSW_SY_HEAT 3
`define FSW_SY_BTN 4
`define FSW_SY_BOOT 5
`define FSW_SY_W 6

// reset values and settle end count
`define FSW_TTL_RST 2'h0
`define FSW_ISO_RST 4'h0
`define FSW_SETTLE_DONE 2'h3

`endif

// >>> fsw_pkg.sv
// types shared by the fault watchdog design
package fsw_pkg;

    // safe state of one logic-level output lane
    typedef enum logic [1:0] {
        FSW_SAFE_LOW,
        FSW_SAFE_HIGH,
        FSW_SAFE_HIZ
    } fsw_safe_t;

    // watchdog expiry action
    typedef enum logic [1:0] {
        FSW_WD_NOTIFY,
        FSW_WD_DRIVE,
        FSW_WD_HALT
    } fsw_wd_act_t;

    // supervisor state
    typedef enum logic {
        FSW_RUN,
        FSW_FAULT
    } fsw_state_t;

    // watchdog configuration from software
    typedef struct packed {
        logic arm;
        fsw_wd_act_t action;
        logic [15:0] timeout_ms;
    } fsw_wd_cfg_t;

    // safe states applied on a fault when halt mode is in force
    typedef struct packed {
        fsw_safe_t ttl1;
        fsw_safe_t ttl0;
        logic [3:0] iso;
    } fsw_safe_cfg_t;

    // sticky fault causes
    typedef struct packed {
        logic ext;
        logic wd;
        logic heat;
    } fsw_fault_t;

endpackage

// >>> fsw_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ns
module fsw_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous pins and their synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

// >>> fsw_press.sv
// long-press detector for the front-panel reset button
`timescale 1ns/1ns
`include "fsw_defines.svh"
module fsw_press #(
    parameter int HOLD = `FSW_PRESS_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // synchronised button level, high while pressed
    input wire logic pressed,
    // one-cycle pulse once the hold time is reached
    output logic accept
);

    logic [`FSW_PRESS_W-1:0] cnt_ff;
    logic fired_ff;
    logic accept_ff;
    logic at_hold;

    assign at_hold = (cnt_ff == `FSW_PRESS_W'(HOLD - 1));

    // any release restarts the count, so a bounce never sums up
    always_ff @(posedge clk)
    begin
        if (!rst_n || !pressed)
            cnt_ff <= '0;
        else if (!at_hold)
            cnt_ff <= cnt_ff + `FSW_PRESS_W'(1);
    end

    // fire once per press; a held button does not repeat the reset
    always_ff @(posedge clk)
    begin
        if (!rst_n || !pressed)
        begin
            fired_ff <= 1'b0;
            accept_ff <= 1'b0;
        end
        else
        begin
            fired_ff <= fired_ff | at_hold;
            accept_ff <= at_hold & ~fired_ff;
        end
    end

    assign accept = accept_ff;

endmodule

// >>> fsw_equip.sv
// behavioural model of the equipment driving the isolated halt request
`timescale 1ns/1ns
module fsw_equip (
    // clock
    input wire logic clk,
    // bench control: equipment ready, response lag in cycles
    input wire logic ready,
    input wire logic [3:0] lag,
    // isolated halt request, high while ready
    output logic halt_req_pin
);
    logic pin_ff = 1'b1;
    logic [3:0] wait_ff = 4'h0;

    assign halt_req_pin = pin_ff;

    // follow ready lag+1 cycles later; a slow lag mimics a relay
    always_ff @(posedge clk)
    begin
        if (pin_ff == ready)
            wait_ff <= 4'h0;
        else if (wait_ff >= lag)
            pin_ff <= ready;
        else
            wait_ff <= wait_ff + 4'h1;
    end
endmodule

// >>> fsw_top_sva.sv
// assertion checker for the fault supervisor top
`timescale 1ns/1ns
module fsw_top_chk
    import fsw_pkg::*;
#(
    parameter int MS_CYCLES = 20000,
    parameter int PRESS_CYCLES = 40000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and software controls
    input wire logic halt_req_pin,
    input wire logic overheat_pin,
    input wire logic reset_btn_pin,
    input wire fsw_wd_cfg_t wd_cfg,
    input wire fsw_safe_cfg_t safe_cfg,
    input wire logic iso_wr,
    input wire logic [3:0] iso_wr_data,
    // outputs and status
    input wire logic [1:0] ttl_out,
    input wire logic [1:0] ttl_oe,
    input wire logic [3:0] iso_out,
    input wire fsw_fault_t fault,
    input wire logic halted,
    input wire logic health_red,
    input wire logic halt_mode_active,
    input wire logic wd_expired,
    input wire logic panel_reset
);
    int btn_run_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // raw press length; the synchroniser adds lag, hence the margin below
    always_ff @(posedge clk)
    begin
        if (!rst_n || !reset_btn_pin)
            btn_run_ff <= 0;
        else
            btn_run_ff <= btn_run_ff + 1;
    end

    sequence s_heat_held;
        (overheat_pin && !panel_reset) [*8];
    endsequence

    sequence s_ext_held;
        (halt_mode_active && !halt_req_pin && !panel_reset) [*8];
    endsequence

    chk_heat_halts: assert property (
        s_heat_held |-> fault.heat && halted)
        else $error("overheat did not halt");
    chk_ext_fires: assert property (
        s_ext_held |-> fault.ext && halted)
        else $error("halt request not recorded");
    chk_ext_gated: assert property (
        $rose(fault.ext) |-> halt_mode_active)
        else $error("halt request taken without halt mode");
    chk_red_halt: assert property (
        halted |-> health_red && fault != 3'h0)
        else $error("halted without red or cause");
    chk_fault_hold: assert property (
        $fell(halted) || $fell(|fault) |->
        panel_reset || $past(panel_reset))
        else $error("fault cleared without reset");
    chk_safe_out: assert property (
        $rose(halted) && halt_mode_active |->
        iso_out == safe_cfg.iso &&
        ttl_oe[0] == (safe_cfg.ttl0 != FSW_SAFE_HIZ))
        else $error("safe states not applied");
    chk_out_frozen: assert property (
        halted && $past(halted) |->
        $stable(iso_out) && $stable(ttl_out) && $stable(ttl_oe))
        else $error("outputs moved while halted");
    chk_iso_write: assert property (
        iso_wr && !halted |->
        ##2 (halted || iso_out == $past(iso_wr_data, 2)))
        else $error("isolated write not applied");
    chk_wd_drive: assert property (
        wd_expired && wd_cfg.arm && !halted &&
        wd_cfg.action == FSW_WD_DRIVE |-> ttl_out[0])
        else $error("expiry not driven on output");
    chk_wd_disarm: assert property (
        !wd_cfg.arm [*3] |-> !wd_expired)
        else $error("expiry kept after disarm");
    chk_panel_press: assert property (
        panel_reset |->
        $past(btn_run_ff, 3) >= PRESS_CYCLES - 3 ##1 !panel_reset)
        else $error("panel reset without long press");
endmodule

bind fsw_top fsw_top_chk #(.MS_CYCLES(MS_CYCLES), .PRESS_CYCLES(PRESS_CYCLES))
    u_chk (.clk, .rst_n, .halt_req_pin, .overheat_pin, .reset_btn_pin,
    .wd_cfg, .safe_cfg, .iso_wr, .iso_wr_data, .ttl_out, .ttl_oe, .iso_out,
    .fault, .halted, .health_red, .halt_mode_active, .wd_expired,
    .panel_reset);

// >>> fsw_top_bench.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ns
module fsw_top_bench
    import fsw_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ready = 1'b1;
    logic [3:0] lag = 4'h0;
    logic halt_req_pin;
    logic overheat_pin = 1'b0;
    logic reset_btn_pin = 1'b0;
    logic protect_boot_pin = 1'b0;
    logic [1:0] gp_in_pin = 2'h0;
    logic halt_mode_en = 1'b0;
    fsw_wd_cfg_t wd_cfg = '0;
    logic wd_service = 1'b0;
    fsw_safe_cfg_t safe_cfg = '0;
    logic ttl_wr = 1'b0;
    logic [1:0] ttl_wr_data = 2'h0;
    logic iso_wr = 1'b0;
    logic [3:0] iso_wr_data = 4'h0;
    logic [1:0] ttl_out, ttl_oe, gp_in_val, e_ttl;
    logic [3:0] iso_out, e_iso;
    fsw_fault_t fault;
    logic halted, health_red, halt_mode_active, wd_expired, panel_reset;
    int err_count = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    int pulses;

    fsw_top #(.MS_CYCLES(4), .PRESS_CYCLES(8)) dut (.clk, .rst_n,
        .halt_req_pin, .overheat_pin, .reset_btn_pin, .protect_boot_pin,
        .gp_in_pin, .halt_mode_en, .wd_cfg, .wd_service, .safe_cfg, .ttl_wr,
        .ttl_wr_data, .iso_wr, .iso_wr_data, .ttl_out, .ttl_oe, .iso_out,
        .gp_in_val, .fault, .halted, .health_red, .halt_mode_active,
        .wd_expired, .panel_reset);

    fsw_equip equip (.clk, .ready, .lag, .halt_req_pin);

    // 50 ns clock
    initial
    begin
        forever #25 clk = ~clk;
    end

    task summarize;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000)
        begin
            err_count++;
            summarize();
        end
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        halt_mode_en <= 1'b0;
        protect_boot_pin <= 1'b0;
        overheat_pin <= 1'b0;
        wd_cfg <= '0;
        ready <= 1'b1;
        lag <= 4'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        tick(4);
    endtask

    // halted, causes and ttl levels after expiry for each action
    function automatic logic [7:0] wd_want(input int a);
        case (a)
            0: return 8'h00;
            1: return 8'h01;
            default: return 8'h29;
        endcase
    endfunction

    initial
    begin
        void'($urandom(32'hF1667E61));
        do_reset();
        // random software writes; isolated data moves afterwards without a strobe
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            gp_in_pin <= 2'($urandom_range(3));
            e_iso = 4'($urandom_range(15));
            e_ttl = 2'($urandom_range(3));
            iso_wr <= 1'b1;
            iso_wr_data <= e_iso;
            ttl_wr <= 1'b1;
            ttl_wr_data <= e_ttl;
            @(posedge clk);
            iso_wr <= 1'b0;
            ttl_wr <= 1'b0;
            iso_wr_data <= ~e_iso;
            tick(4);
            chk(8'(gp_in_val), 8'(gp_in_pin));
            chk({ttl_oe, ttl_out, iso_out}, {2'h3, e_ttl, e_iso});
        end
        // slow equipment drops ready while halt mode is on
        @(posedge clk);
        e_iso = 4'($urandom_range(15, 1));
        safe_cfg <= '{FSW_SAFE_HIGH, FSW_SAFE_HIZ, e_iso};
        halt_mode_en <= 1'b1;
        lag <= 4'h5;
        ready <= 1'b0;
        for (int i = 0; i < 40 && halted !== 1'b1; i++) @(posedge clk);
        tick(2);
        chk(8'(fault), 8'h04);
        chk(8'({health_red, ttl_oe, ttl_out[1]}), 8'h0D);
        chk(8'(iso_out), 8'(e_iso));
        // writes refused and halt mode kept while halted
        @(posedge clk);
        iso_wr <= 1'b1;
        iso_wr_data <= ~e_iso;
        halt_mode_en <= 1'b0;
        ready <= 1'b1;
        @(posedge clk);
        iso_wr <= 1'b0;
        tick(8);
        chk(8'({halted, halt_mode_active}), 8'h03);
        chk(8'(iso_out), 8'(e_iso));
        // a short press is refused, a long one fires once
        @(posedge clk);
        reset_btn_pin <= 1'b1;
        repeat (6) @(posedge clk);
        reset_btn_pin <= 1'b0;
        tick(6);
        chk(8'(halted), 8'h01);
        pulses = 0;
        @(posedge clk);
        reset_btn_pin <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            tick(1);
            pulses += int'(panel_reset);
        end
        @(posedge clk);
        reset_btn_pin <= 1'b0;
        tick(4);
        chk(8'(pulses), 8'h01);
        chk(8'({halted, halt_mode_active, fault}), 8'h00);
        // protected boot ignores halt mode; overheat still halts
        @(posedge clk);
        protect_boot_pin <= 1'b1;
        halt_mode_en <= 1'b1;
        ready <= 1'b0;
        tick(15);
        chk(8'({halted, halt_mode_active}), 8'h00);
        @(posedge clk);
        overheat_pin <= 1'b1;
        tick(6);
        chk(8'({halted, fault, ttl_oe}), 8'h27);
        chk(8'(iso_out), 8'h00);
        do_reset();
        // each watchdog action: serviced, then left to expire
        for (int a = 0; a < 3; a++)
        begin
            @(posedge clk);
            halt_mode_en <= (a == 2);
            safe_cfg <= '{FSW_SAFE_LOW, FSW_SAFE_HIGH, 4'h5};
            wd_cfg <= '{1'b1, fsw_wd_act_t'(a), 16'h0003};
            repeat (4)
            begin
                tick(4);
                @(posedge clk);
                wd_service <= 1'b1;
                @(posedge clk);
                wd_service <= 1'b0;
            end
            tick(6);
            chk(8'(wd_expired), 8'h00);
            for (int i = 0; i < 30 && wd_expired !== 1'b1; i++) @(posedge clk);
            tick(3);
            chk(8'({halted, fault, ttl_out}), wd_want(a));
            @(posedge clk);
            wd_cfg.arm <= 1'b0;
            tick(4);
            chk(8'({wd_expired, halted}), 8'(a == 2));
            do_reset();
        end
        // a zero timeout is taken as one millisecond, not as instant expiry
        @(posedge clk);
        wd_cfg <= '{1'b1, FSW_WD_NOTIFY, 16'h0000};
        tick(5);
        chk(8'(wd_expired), 8'h00);
        tick(1);
        chk(8'(wd_expired), 8'h01);
        summarize();
    end
endmodule
